// ### rtl/tmc_regs.v
// Transmit modulation configuration registers with a small transmit bit path.
//
// Functional notes
// R1 - Two-bit power code picks output level, 11 highest, 00 lowest.
// R2 - Power code resets to 11; upper bits of that register read zero.
// R3 - Rate is 1000 times rate word over 2^16, or 2^21 with scale set.
// R4 - Rate word resets to 0x0A0D, giving about 39.3 kbps.
// R5 - Host should set the scale bit below 30 kbps.
// R6 - Packet handler powers down in low power when its bit is set.
// R7 - Manchester preamble is all ones or all zeros by polarity bit.
// R8 - Manchester inversion bit inverts symbol polarity.
// R9 - Manchester enable bit encodes the data path.
// R10 - Whitening enable bit whitens the data stream.
// R11 - Clock routing: none, general pin, serial out, interrupt pin.
// R12 - Source: general pin, serial in while select high, FIFO, PN9.
// R13 - Data inversion bit inverts transmit and receive data.
// R14 - Type: carrier, OOK, FSK, GFSK; GFSK direct needs a clock route.
// R15 - Deviation is 625 Hz times 9-bit value, top bit in modulation select.
// R16 - Deviation low resets to 0x20, modulation select to zero.
// R17 - Host keeps modulation index between 1 and 32.
// R18 - Offset is 10-bit two's complement, step scales with band select.
// R19 - Offset reads return the last frequency correction result.
// R20 - Band select chooses high range and doubles the offset step.
// R21 - Reserved bits read zero and ignore writes.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.vh"

module tmc_regs #(
    parameter RATE_LOG2_FAST = 16,
    parameter RATE_LOG2_SLOW = 21
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [8:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        low_power_mode,
    input  wire        preamble_phase,
    input  wire        tx_data_gpio,
    input  wire        serial_in_pin,
    input  wire        chip_select_pin,
    input  wire        tx_data_fifo,
    input  wire        rx_data_raw,
    input  wire [9:0]  afc_result,
    output reg  [1:0]  power_code,
    output reg         packet_handler_on,
    output reg         whitening_on,
    output reg  [1:0]  modulation_type,
    output reg  [8:0]  deviation_value,
    output reg  [9:0]  offset_value,
    output reg         high_band,
    output reg         tx_bit_tick,
    output reg         tx_symbol,
    output reg         rx_data_out,
    output reg         clk_on_gpio,
    output reg         clk_on_serial_out_pin,
    output reg         clk_on_interrupt_pin,
    output reg         config_error
);

    reg [1:0]  power_reg;
    reg [7:0]  rate_hi_reg;
    reg [7:0]  rate_lo_reg;
    reg [5:0]  line_code_reg;
    reg [7:0]  mod_sel_reg;
    reg [7:0]  dev_lo_reg;
    reg [7:0]  ofs_lo_reg;
    reg [1:0]  ofs_hi_reg;
    reg        band_reg;
    reg        ack_reg;
    reg [20:0] phase_reg;
    reg        half_reg;
    reg [31:0] rdata_next;
    reg        src_bit;
    reg        coded;
    reg [21:0] phase_sum;

    wire [6:0]  idx     = avs_address[8:2];
    wire        wr_en   = avs_write && ack_reg && avs_byteenable[0];
    wire [7:0]  wd      = avs_writedata[7:0];
    wire [15:0] rate_w  = {rate_hi_reg, rate_lo_reg};
    wire        scale   = line_code_reg[`TMC_LC_SCALE];
    wire        man_en  = line_code_reg[`TMC_LC_MAN_EN];
    wire [1:0]  clk_sel = mod_sel_reg[`TMC_MS_CLK_HI:`TMC_MS_CLK_LO];
    wire [1:0]  src_sel = mod_sel_reg[`TMC_MS_SRC_HI:`TMC_MS_SRC_LO];
    wire        pn_bit;

    // ------------------------------------------------------------------------
    // Internal sequence source.
    // ------------------------------------------------------------------------
    tmc_pn9 u_pn9 (
        .clk     (clk),
        .rst_b   (rst_b),
        .step    (tx_bit_tick),
        .bit_out (pn_bit)
    );

    // ------------------------------------------------------------------------
    // Bus slave: one wait state, writes land on the acknowledge edge.
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_reg         <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            ack_reg         <= (avs_read || avs_write) && !ack_reg;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_reg     <= `TMC_RST_POWER;     // [R2]
            rate_hi_reg   <= `TMC_RST_RATE_HI;   // [R4]
            rate_lo_reg   <= `TMC_RST_RATE_LO;   // [R4]
            line_code_reg <= `TMC_RST_LINE_CODE;
            mod_sel_reg   <= `TMC_RST_MOD_SEL;   // [R16]
            dev_lo_reg    <= `TMC_RST_DEV_LO;    // [R16]
            ofs_lo_reg    <= `TMC_RST_OFS_LO;
            ofs_hi_reg    <= `TMC_RST_OFS_HI;
            band_reg      <= `TMC_RST_BAND;
        end else if (wr_en) begin
            case (idx)
                `TMC_IDX_POWER:     power_reg     <= wd[1:0];  // [R21]
                `TMC_IDX_RATE_HI:   rate_hi_reg   <= wd;
                `TMC_IDX_RATE_LO:   rate_lo_reg   <= wd;
                `TMC_IDX_LINE_CODE: line_code_reg <= wd[5:0];  // [R21]
                `TMC_IDX_MOD_SEL:   mod_sel_reg   <= wd;
                `TMC_IDX_DEV_LO:    dev_lo_reg    <= wd;
                `TMC_IDX_OFS_LO:    ofs_lo_reg    <= wd;
                `TMC_IDX_OFS_HI:    ofs_hi_reg    <= wd[1:0];  // [R21]
                `TMC_IDX_BAND:      band_reg      <= wd[0];
                default: begin
                end
            endcase
        end
    end

    always @* begin
        rdata_next = 32'h0000_0000;
        case (idx)
            `TMC_IDX_POWER:     rdata_next[1:0] = power_reg;             // [R21]
            `TMC_IDX_RATE_HI:   rdata_next[7:0] = rate_hi_reg;
            `TMC_IDX_RATE_LO:   rdata_next[7:0] = rate_lo_reg;
            `TMC_IDX_LINE_CODE: rdata_next[5:0] = line_code_reg;
            `TMC_IDX_MOD_SEL:   rdata_next[7:0] = mod_sel_reg;
            `TMC_IDX_DEV_LO:    rdata_next[7:0] = dev_lo_reg;
            `TMC_IDX_OFS_LO:    rdata_next[7:0] = afc_result[7:0];      // [R19]
            `TMC_IDX_OFS_HI:    rdata_next[1:0] = afc_result[9:8];      // [R19]
            `TMC_IDX_BAND:      rdata_next[0]   = band_reg;
            `TMC_IDX_STATUS:    rdata_next[0]   = config_error;
            default:            rdata_next      = 32'h0000_0000;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            avs_readdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------------------
    // Bit clock: a phase accumulator adds the rate word every cycle.
    // ------------------------------------------------------------------------
    always @* begin
        phase_sum = {1'b0, phase_reg} + {6'h00, rate_w};
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg   <= 21'h000000;
            tx_bit_tick <= 1'b0;
        end else if (scale) begin                                       // [R3]
            phase_reg   <= phase_sum[RATE_LOG2_SLOW-1:0];
            tx_bit_tick <= phase_sum[RATE_LOG2_SLOW];
        end else begin
            phase_reg   <= {5'h00, phase_sum[RATE_LOG2_FAST-1:0]};
            tx_bit_tick <= phase_sum[RATE_LOG2_FAST];
        end
    end

    // ------------------------------------------------------------------------
    // Transmit data path: source, inversion, line coding.
    // ------------------------------------------------------------------------
    always @* begin
        case (src_sel)                                                  // [R12]
            `TMC_SRC_GPIO: src_bit = tx_data_gpio;
            `TMC_SRC_SDI:  src_bit = chip_select_pin & serial_in_pin;
            `TMC_SRC_FIFO: src_bit = tx_data_fifo;
            `TMC_SRC_PN9:  src_bit = pn_bit;
            default:       src_bit = 1'b0;
        endcase
        src_bit = src_bit ^ mod_sel_reg[`TMC_MS_DATA_INV];              // [R13]
        if (man_en && preamble_phase) begin
            coded = line_code_reg[`TMC_LC_PRE_POL];                     // [R7]
        end else if (man_en) begin
            coded = src_bit ^ half_reg ^ line_code_reg[`TMC_LC_MAN_INV]; // [R9] [R8]
        end else begin
            coded = src_bit;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_reg    <= 1'b0;
            tx_symbol   <= 1'b0;
            rx_data_out <= 1'b0;
        end else begin
            if (tx_bit_tick) begin
                half_reg  <= man_en ? ~half_reg : 1'b0;
                tx_symbol <= coded;
            end
            rx_data_out <= rx_data_raw ^ mod_sel_reg[`TMC_MS_DATA_INV]; // [R13]
        end
    end

    // ------------------------------------------------------------------------
    // Configuration outputs.
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_code            <= `TMC_RST_POWER;
            packet_handler_on     <= 1'b1;
            whitening_on          <= 1'b0;
            modulation_type       <= `TMC_MOD_CW;
            deviation_value       <= {1'b0, `TMC_RST_DEV_LO};
            offset_value          <= 10'h000;
            high_band             <= 1'b0;
            clk_on_gpio           <= 1'b0;
            clk_on_serial_out_pin <= 1'b0;
            clk_on_interrupt_pin  <= 1'b0;
            config_error          <= 1'b0;
        end else begin
            power_code        <= power_reg;                                    // [R1]
            packet_handler_on <= !(line_code_reg[`TMC_LC_PH_PWDN] && low_power_mode); // [R6]
            whitening_on      <= line_code_reg[`TMC_LC_WHITE_EN];              // [R10]
            modulation_type   <= mod_sel_reg[`TMC_MS_TYPE_HI:`TMC_MS_TYPE_LO]; // [R14]
            deviation_value   <= {mod_sel_reg[`TMC_MS_DEV_MSB], dev_lo_reg};   // [R15]
            offset_value      <= {ofs_hi_reg, ofs_lo_reg};                     // [R18]
            high_band         <= band_reg;                                     // [R20]
            clk_on_gpio           <= (clk_sel == `TMC_CLK_GPIO);               // [R11]
            clk_on_serial_out_pin <= (clk_sel == `TMC_CLK_SDO);                // [R11]
            clk_on_interrupt_pin  <= (clk_sel == `TMC_CLK_IRQ);                // [R11]
            config_error <= (clk_sel == `TMC_CLK_NONE) &&
                            (mod_sel_reg[1:0] == `TMC_MOD_GFSK) &&
                            !src_sel[1];                                       // [R14]
        end
    end

endmodule // tmc_regs

`default_nettype wire

// ### inc/tmc_defines.vh
// Register offsets, field positions, reset values and timing constants of the transmit config bank.
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------------------
`define TMC_IDX_POWER        7'h6D
`define TMC_IDX_RATE_HI      7'h6E
`define TMC_IDX_RATE_LO      7'h6F
`define TMC_IDX_LINE_CODE    7'h70
`define TMC_IDX_MOD_SEL      7'h71
`define TMC_IDX_DEV_LO       7'h72
`define TMC_IDX_OFS_LO       7'h73
`define TMC_IDX_OFS_HI       7'h74
`define TMC_IDX_BAND         7'h75
`define TMC_IDX_STATUS       7'h7F

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TMC_RST_POWER        2'h3
`define TMC_RST_RATE_HI      8'h0A
`define TMC_RST_RATE_LO      8'h0D
`define TMC_RST_LINE_CODE    6'h00
`define TMC_RST_MOD_SEL      8'h00
`define TMC_RST_DEV_LO       8'h20
`define TMC_RST_OFS_LO       8'h00
`define TMC_RST_OFS_HI       2'h0
`define TMC_RST_BAND         1'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TMC_LC_SCALE         5
`define TMC_LC_PH_PWDN       4
`define TMC_LC_PRE_POL       3
`define TMC_LC_MAN_INV       2
`define TMC_LC_MAN_EN        1
`define TMC_LC_WHITE_EN      0
`define TMC_MS_CLK_HI        7
`define TMC_MS_CLK_LO        6
`define TMC_MS_SRC_HI        5
`define TMC_MS_SRC_LO        4
`define TMC_MS_DATA_INV      3
`define TMC_MS_DEV_MSB       2
`define TMC_MS_TYPE_HI       1
`define TMC_MS_TYPE_LO       0

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define TMC_CLK_NONE         2'h0
`define TMC_CLK_GPIO         2'h1
`define TMC_CLK_SDO          2'h2
`define TMC_CLK_IRQ          2'h3
`define TMC_SRC_GPIO         2'h0
`define TMC_SRC_SDI          2'h1
`define TMC_SRC_FIFO         2'h2
`define TMC_SRC_PN9          2'h3
`define TMC_MOD_CW           2'h0
`define TMC_MOD_OOK          2'h1
`define TMC_MOD_FSK          2'h2
`define TMC_MOD_GFSK         2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TMC_BASE_RATE_KBPS   1000
`define TMC_CLK_MHZ          25

`endif

// ### rtl/tmc_pn9.v
// Nine-bit pseudo-random sequence generator for the internal modulation source.
`timescale 1ns/1ps
`default_nettype none

module tmc_pn9 (
    input  wire clk,
    input  wire rst_b,
    input  wire step,
    output reg  bit_out
);

    reg [8:0] lfsr_reg;

    // ------------------------------------------------------------------------
    // Shift register, polynomial x^9 + x^5 + 1.
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lfsr_reg <= 9'h1FF;
            bit_out  <= 1'b1;
        end else if (step) begin
            lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
            bit_out  <= lfsr_reg[8];
        end
    end

endmodule // tmc_pn9

`default_nettype wire

// ### verification/tmc_regs_sva.sv
// Concurrent checks on the ports of the transmit config bank.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.vh"
module tmc_regs_sva (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [8:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        low_power_mode,
    input wire logic [1:0]  power_code,
    input wire logic        packet_handler_on,
    input wire logic        whitening_on,
    input wire logic [1:0]  modulation_type,
    input wire logic        clk_on_gpio,
    input wire logic        clk_on_serial_out_pin,
    input wire logic        clk_on_interrupt_pin,
    input wire logic        config_error
);
    // ------------------------------------------------------------------
    // Shadow of the written bytes, and a copy one clock later.
    // ------------------------------------------------------------------
    logic        wr_ok;
    logic [6:0]  ix;
    logic [1:0]  pw_reg;
    logic [5:0]  lc_reg;
    logic [7:0]  ms_reg;
    logic [14:0] dly_reg;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign ix = avs_address[8:2];
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pw_reg  <= 2'h3;
            lc_reg  <= 6'h00;
            ms_reg  <= 8'h00;
            dly_reg <= 15'h0000;
        end else begin
            dly_reg <= {ms_reg, lc_reg, low_power_mode};
            if (wr_ok && ix == `TMC_IDX_POWER) begin
                pw_reg <= avs_writedata[1:0];
            end
            if (wr_ok && ix == `TMC_IDX_LINE_CODE) begin
                lc_reg <= avs_writedata[5:0];
            end
            if (wr_ok && ix == `TMC_IDX_MOD_SEL) begin
                ms_reg <= avs_writedata[7:0];
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    answer_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one cycle");
    wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest [*2])
        else $error("waitrequest low for more than one cycle");
    power_follow_a: assert property (power_code == $past(pw_reg))
        else $error("power code does not follow its register");
    whiten_follow_a: assert property (whitening_on == dly_reg[1])
        else $error("whitening output does not follow its bit");
    ph_pwdn_a: assert property (packet_handler_on == !(dly_reg[5] && dly_reg[0]))
        else $error("packet handler power state wrong");
    mod_type_a: assert property (modulation_type == dly_reg[8:7])
        else $error("modulation type does not follow its field");
    clk_route_a: assert property ({clk_on_interrupt_pin, clk_on_serial_out_pin, clk_on_gpio} ==
        {dly_reg[14:13] == 2'h3, dly_reg[14:13] == 2'h2, dly_reg[14:13] == 2'h1})
        else $error("data clock routing decode wrong");
    cfg_err_a: assert property (config_error ==
        (dly_reg[8:7] == 2'h3 && !dly_reg[12] && dly_reg[14:13] == 2'h0))
        else $error("configuration error flag wrong");
endmodule // tmc_regs_sva
bind tmc_regs tmc_regs_sva chk_u (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_waitrequest, .low_power_mode, .power_code,
    .packet_handler_on, .whitening_on, .modulation_type, .clk_on_gpio,
    .clk_on_serial_out_pin, .clk_on_interrupt_pin, .config_error);
`default_nettype wire

// ### verification/tmc_host.sv
// Avalon-MM host model that issues register cycles to the config bank.
`timescale 1ns/1ps
`default_nettype none
module tmc_host (
    input  wire logic        clk,
    output var  logic [8:0]  adr,
    output var  logic        rd,
    output var  logic        wr,
    output var  logic [31:0] wd,
    output var  logic [3:0]  be,
    input  wire logic [31:0] rdat,
    input  wire logic        wait_r
);
    initial begin
        {adr, rd, wr, wd, be} = '0;
    end
    // Holds the request until waitrequest is seen low, then scrambles the lines.
    task automatic xfer(input logic w, input logic [6:0] ix, input logic [7:0] d,
                        input logic [3:0] b, output logic [31:0] q);
        @(posedge clk);
        adr <= {ix, 2'b00};
        rd  <= !w;
        wr  <= w;
        wd  <= {24'h000000, d};
        be  <= b;
        @(posedge clk);
        while (wait_r !== 1'b0) begin
            @(posedge clk);
        end
        q = rdat;
        rd  <= 1'b0;
        wr  <= 1'b0;
        adr <= ~adr;
        wd  <= ~wd;
    endtask
endmodule // tmc_host
`default_nettype wire

// ### verification/tx_modulation_config_regs_test.sv
// Self-checking bench for the transmit config bank.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.vh"
module tx_modulation_config_regs_test;
    logic        clk = 1'b0, rst_b = 1'b0, low_power_mode = 1'b0, preamble_phase = 1'b0;
    logic        tx_data_gpio = 1'b0, serial_in_pin = 1'b1, chip_select_pin = 1'b0;
    logic        tx_data_fifo = 1'b1, rx_data_raw = 1'b0;
    logic [9:0]  afc_result = 10'h2AA, offset_value;
    logic [8:0]  avs_address, deviation_value;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    logic [1:0]  power_code, modulation_type;
    logic        avs_read, avs_write, avs_waitrequest, packet_handler_on, whitening_on;
    logic        high_band, tx_bit_tick, tx_symbol, rx_data_out, clk_on_gpio;
    logic        clk_on_serial_out_pin, clk_on_interrupt_pin, config_error, s, t;
    int          bad_count = 0, check_count = 0, n;
    always #20 clk = ~clk;
    tmc_regs dut_u (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .low_power_mode, .preamble_phase,
        .tx_data_gpio, .serial_in_pin, .chip_select_pin, .tx_data_fifo, .rx_data_raw,
        .afc_result, .power_code, .packet_handler_on, .whitening_on, .modulation_type,
        .deviation_value, .offset_value, .high_band, .tx_bit_tick, .tx_symbol, .rx_data_out,
        .clk_on_gpio, .clk_on_serial_out_pin, .clk_on_interrupt_pin, .config_error);
    tmc_host host_u (.clk, .adr(avs_address), .rd(avs_read), .wr(avs_write),
        .wd(avs_writedata), .be(avs_byteenable), .rdat(avs_readdata), .wait_r(avs_waitrequest));
    // ------------------------------------------------------------------
    // Shared helpers.
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic w(input logic [6:0] ix, input logic [7:0] d);
        host_u.xfer(1'b1, ix, d, 4'hF, q);
    endtask
    task automatic r(input logic [6:0] ix, input logic [7:0] e, input string nm);
        host_u.xfer(1'b0, ix, 8'h00, 4'hF, q);
        chk(nm, {24'h000000, e}, q);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask
    task automatic sym(output logic v);
        int k;
        k = 0;
        settle();
        while (tx_bit_tick !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        v = tx_symbol;
    endtask
    task automatic ticks(output int c);
        c = 0;
        repeat (70) @(posedge clk);
        repeat (256) begin
            @(posedge clk);
            if (tx_bit_tick === 1'b1) c++;
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_regs;
        r(`TMC_IDX_POWER, 8'h03, "power rst");
        r(`TMC_IDX_RATE_HI, 8'h0A, "rate hi rst");
        r(`TMC_IDX_RATE_LO, 8'h0D, "rate lo rst");
        r(`TMC_IDX_MOD_SEL, 8'h00, "mod sel rst");
        r(`TMC_IDX_DEV_LO, 8'h20, "dev lo rst");
        w(`TMC_IDX_LINE_CODE, 8'hC0);
        w(`TMC_IDX_MOD_SEL, 8'h04);
        w(`TMC_IDX_DEV_LO, 8'h40);
        w(7'h10, 8'hFF);
        host_u.xfer(1'b1, `TMC_IDX_DEV_LO, 8'h11, 4'hE, q);
        r(`TMC_IDX_LINE_CODE, 8'h00, "line rsvd");
        r(7'h10, 8'h00, "unmapped");
        r(`TMC_IDX_DEV_LO, 8'h40, "dev lo");
        chk("dev out", 32'h140, deviation_value);
        for (int i = 0; i < 4; i++) begin
            w(`TMC_IDX_POWER, {6'h3F, i[1:0]});
            r(`TMC_IDX_POWER, {6'h00, i[1:0]}, "power rsvd");
            chk("power code", i, power_code);
        end
        $display("test regs done");
    endtask
    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            w(`TMC_IDX_MOD_SEL, {i[1:0], 4'h0, i[1:0]});
            settle();
            chk("type", i, modulation_type);
            chk("route", (1 << i) >> 1, {clk_on_interrupt_pin, clk_on_serial_out_pin, clk_on_gpio});
            w(`TMC_IDX_MOD_SEL, {2'h0, i[1:0], 4'h3});
            settle();
            chk("gfsk err", i < 2, config_error);
            r(`TMC_IDX_STATUS, {7'h00, i < 2}, "status");
        end
        $display("test modes done");
    endtask
    task automatic t_rate;
        w(`TMC_IDX_MOD_SEL, 8'h02);
        w(`TMC_IDX_RATE_HI, 8'h40);
        w(`TMC_IDX_RATE_LO, 8'h00);
        ticks(n);
        chk("fast ticks", 64, n);
        w(`TMC_IDX_LINE_CODE, 8'h20);
        w(`TMC_IDX_RATE_HI, 8'h80);
        ticks(n);
        chk("slow ticks", 4, n);
        w(`TMC_IDX_RATE_HI, 8'h40);
        $display("test rate done");
    endtask
    task automatic t_path;
        w(`TMC_IDX_LINE_CODE, 8'h11);
        low_power_mode <= 1'b1;
        settle();
        chk("ph off", 0, packet_handler_on);
        chk("white", 1, whitening_on);
        low_power_mode <= 1'b0;
        rx_data_raw <= 1'b1;
        tx_data_gpio <= 1'b1;
        w(`TMC_IDX_MOD_SEL, 8'h0A);
        settle();
        chk("ph on", 1, packet_handler_on);
        chk("rx inv", 0, rx_data_out);
        sym(s);
        chk("sym inv", 0, s);
        w(`TMC_IDX_MOD_SEL, 8'h12);
        sym(s);
        chk("sdi gated", 0, s);
        chip_select_pin <= 1'b1;
        sym(s);
        chk("sdi open", 1, s);
        tx_data_gpio <= 1'b0;
        w(`TMC_IDX_MOD_SEL, 8'h22);
        sym(s);
        chk("fifo src", 1, s);
        w(`TMC_IDX_MOD_SEL, 8'h32);
        n = 0;
        repeat (16) begin
            sym(s);
            n += int'(s === 1'b1);
        end
        chk("pn9 mix", 1, n > 0 && n < 16);
        tx_data_gpio <= 1'b1;
        w(`TMC_IDX_MOD_SEL, 8'h02);
        w(`TMC_IDX_LINE_CODE, 8'h02);
        sym(s);
        sym(t);
        chk("manch toggle", 1, s !== t);
        preamble_phase <= 1'b1;
        w(`TMC_IDX_LINE_CODE, 8'h0A);
        sym(s);
        chk("preamble one", 1, s);
        w(`TMC_IDX_LINE_CODE, 8'h02);
        sym(s);
        chk("preamble zero", 0, s);
        preamble_phase <= 1'b0;
        $display("test path done");
    endtask
    task automatic t_offset;
        w(`TMC_IDX_OFS_LO, 8'h55);
        r(`TMC_IDX_OFS_LO, 8'hAA, "afc read");
        w(`TMC_IDX_OFS_HI, 8'h03);
        w(`TMC_IDX_BAND, 8'h01);
        settle();
        chk("offset", 32'h355, offset_value);
        chk("band", 1, high_band);
        $display("test offset done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_modes();
        t_rate();
        t_path();
        t_offset();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end
endmodule // tx_modulation_config_regs_test
`default_nettype wire
